// ---- rtl/pss_top.sv ----
// top: apb register file, signature, security cell, programming and output registers
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R01] a 64-bit rewritable user signature store holds any user data.
// [R02] the signature reads back whether or not the device is secured.
// [R03] the signature is part of the configuration checksum.
// [R04] once secured, reads of the configuration words are refused.
// [R05] the security cell is cleared only by a full reprogramming cycle; here the erase phase of any started cycle clears it.
// [R06] each programming cycle erases the configuration first by itself.
// [R07] preload forces each registered output high or low synchronously.
// [R08] the programmer applies preload whenever a test vector needs it.
// [R09] after power-up every register is cleared within 45 us.
// [R10] after reset every enabled registered output pin reads high.
// [R11] the clock must be valid within 100 ns of power being applied.
// [R12] no clock edges should be used before reset completes.
// [R13] on the pull-up variant an open input is seen as one.
module pss_top
  import pss_pkg::*;
#(
  parameter int RESET_COUNT = RESET_CYCLES,
  parameter bit HAS_PULLUPS = 1'b1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_REGS-1:0] i_pin,
  input wire logic [NUM_REGS-1:0] i_pin_float,
  input wire logic [NUM_REGS-1:0] i_oe,
  output logic [NUM_REGS-1:0] o_pin,
  output logic [NUM_REGS-1:0] o_pin_oe,
  output logic o_reset_done
);
  logic [SIG_BITS-1:0] user_signature;
  logic [CFG_WORDS*32-1:0] cfg;
  logic [31:0] checksum;
  logic secured;
  logic read_denied;
  logic [$clog2(CFG_WORDS)-1:0] cfg_addr;
  logic [NUM_REGS-1:0] polarity;
  logic [NUM_REGS-1:0] preload_val;
  logic preload_pulse;
  logic [NUM_REGS-1:0] q;
  logic [NUM_REGS-1:0] next_q;
  logic [NUM_REGS-1:0] pin_s1;
  logic [NUM_REGS-1:0] pin_s2;
  logic [NUM_REGS-1:0] flt_s1;
  logic [NUM_REGS-1:0] flt_s2;
  logic [NUM_REGS-1:0] pin_seen;
  logic [$clog2(RESET_COUNT+1)-1:0] rst_cnt;
  logic reset_busy;
  pss_prog_t prog_state;
  logic [$clog2(CFG_WORDS+1)-1:0] erase_idx;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  // per-register write strobes, each high only in the access cycle of a write
  logic wr_ctrl;
  logic wr_sig_lo;
  logic wr_sig_hi;
  logic wr_cfg_addr;
  logic wr_cfg_data;
  logic wr_preload;
  // requests carried by a control write
  logic prog_start_req;
  logic prog_end_req;
  logic secure_req;
  logic preload_req;
  // phase flags of the programming sequence
  logic erasing;
  logic loading;
  logic erase_last;
  // assembled status word and the configuration word picked for readback
  logic [31:0] status_word;
  logic [31:0] cfg_word;
  logic [$clog2(RESET_COUNT+1)-1:0] rst_last;

  // zero-wait apb: every access completes in its first access cycle
  // writes land at the access edge; reads are fetched one edge earlier, in setup,
  // so the registered read data already stands when pready is sampled
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  // address decode of the write strobes
  assign wr_ctrl = wr_en && (i_paddr == OFS_CTRL);
  assign wr_sig_lo = wr_en && (i_paddr == OFS_SIG_LO);
  assign wr_sig_hi = wr_en && (i_paddr == OFS_SIG_HI);
  assign wr_cfg_addr = wr_en && (i_paddr == OFS_CFG_ADDR);
  assign wr_cfg_data = wr_en && (i_paddr == OFS_CFG_DATA);
  assign wr_preload = wr_en && (i_paddr == OFS_PRELOAD);

  // control word: one bit starts or ends programming, one secures, one preloads
  assign prog_start_req = wr_ctrl && i_pwdata[CTRL_PROG_START];
  assign prog_end_req = wr_ctrl && !i_pwdata[CTRL_PROG_START];
  assign secure_req = wr_ctrl && i_pwdata[CTRL_SECURE];
  assign preload_req = wr_ctrl && i_pwdata[CTRL_PRELOAD];

  always_comb begin
    unique case (i_paddr)
      OFS_CTRL, OFS_STATUS, OFS_SIG_LO, OFS_SIG_HI,
      OFS_CFG_ADDR, OFS_CFG_DATA, OFS_PRELOAD, OFS_CHECKSUM: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // last count of the power-up interval, cut to the counter width on purpose
  assign rst_last = ($clog2(RESET_COUNT+1))'(RESET_COUNT - 1);

  // power-up reset counter; the output registers stay cleared meanwhile
  // the count starts at the release edge, so the interval is a fixed number of
  // clocks and never depends on what the bus does in the meantime
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      rst_cnt <= '0;
      reset_busy <= 1'b1;
    end else if (reset_busy) begin
      if (rst_cnt == rst_last) begin
        reset_busy <= 1'b0; // done within the bound, see [R09]
      end else begin
        rst_cnt <= rst_cnt + 1'b1;
      end
    end
  end

  // pins cross in through two flops before any logic reads them
  // only the second flop is read: the first may still be settling after a pin
  // edge that landed close to the clock
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      flt_s1 <= '0;
      flt_s2 <= '0;
    end else begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
      flt_s1 <= i_pin_float;
      flt_s2 <= flt_s1;
    end
  end
  // an undriven pin reads one on the pull-up variant, see [R13]
  assign pin_seen = HAS_PULLUPS ? (pin_s2 | flt_s2) : pin_s2;

  // stand-in array: next state is the sampled pins; the stored polarity is not applied
  assign next_q = pin_seen;

  // phase flags of the programming sequence
  assign erasing = (prog_state == PSS_ERASE);
  assign loading = (prog_state == PSS_WRITE);
  assign erase_last = (erase_idx == ($clog2(CFG_WORDS+1))'(CFG_WORDS - 1));

  // programming sequence: erase every word, then accept data; see [R06]
  // the programmer never asks for an erase: starting a cycle is enough, and no
  // data word is taken until the last word has been cleared
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      prog_state <= PSS_IDLE;
      erase_idx <= '0;
    end else begin
      unique case (prog_state)
        PSS_IDLE: begin
          if (prog_start_req) begin
            prog_state <= PSS_ERASE;
            erase_idx <= '0;
          end
        end
        PSS_ERASE: begin
          if (erase_last) begin
            prog_state <= PSS_WRITE;
          end else begin
            erase_idx <= erase_idx + 1'b1;
          end
        end
        PSS_WRITE: begin
          if (prog_end_req) begin
            prog_state <= PSS_IDLE;
          end
        end
        // the unused code is left at once, so a glitch cannot lock the sequence
        default: begin
          prog_state <= PSS_IDLE;
        end
      endcase
    end
  end

  // configuration store: cleared word by word during erase, written in write phase
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      cfg <= '0;
    end else if (erasing) begin
      cfg[erase_idx[$clog2(CFG_WORDS)-1:0]*32 +: 32] <= 32'h00000000;
    end else if (loading && wr_cfg_data) begin // data outside a cycle is dropped
      cfg[cfg_addr*32 +: 32] <= i_pwdata;
    end
  end

  // the security cell is nonvolatile in silicon; here reset does not clear it
  // only the erase phase of a programming cycle does, see [R05]
  always_ff @(posedge I_REF_CLK) begin
    // erase has priority, so a cycle that has begun always clears the cell during its erase phase
    if (erasing) begin
      secured <= 1'b0;
    end else if (secure_req) begin
      secured <= 1'b1;
    end else if (!I_RESET_N && secured !== 1'b1) begin
      secured <= 1'b0;
    end
  end

  // signature and helper registers, writable any time
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      user_signature <= '0;
      cfg_addr <= '0;
      polarity <= '0;
      preload_val <= '0;
      preload_pulse <= 1'b0;
    end else begin
      // one-cycle pulse; the output registers take the value at the next edge
      preload_pulse <= preload_req; // see [R07]
      if (wr_sig_lo) begin
        user_signature[31:0] <= i_pwdata; // see [R01]
      end
      if (wr_sig_hi) begin
        user_signature[63:32] <= i_pwdata;
      end
      if (wr_cfg_addr) begin
        cfg_addr <= i_pwdata[$clog2(CFG_WORDS)-1:0];
      end
      // polarity is stored and read back only; the pins do not use it
      if (wr_preload) begin
        preload_val <= i_pwdata[NUM_REGS-1:0];
        polarity <= i_pwdata[PRELOAD_POL_LSB +: NUM_REGS];
      end
    end
  end

  // the sum is purely combinational; it settles long before a read can fetch it
  pss_checksum #(
    .WORDS(CFG_WORDS)
  ) u_sum (
    .i_cfg(cfg),
    .i_sig(user_signature),
    .o_sum(checksum)
  );

  // output registers: held clear for the whole power-up interval
  pss_outreg #(
    .N(NUM_REGS)
  ) u_regs (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_clr(reset_busy),
    .i_load(preload_pulse),
    .i_load_val(preload_val),
    .i_next(next_q),
    .i_run(!reset_busy),
    .o_q(q)
  );

  // pins show inverted register q, so a cleared register drives high; see [R10]
  // polarity is left out on purpose: the reset level must not depend on it
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      o_pin <= {NUM_REGS{1'b1}};
      o_pin_oe <= '0;
      o_reset_done <= 1'b0;
    end else begin
      o_pin <= ~q;
      o_pin_oe <= i_oe;
      o_reset_done <= !reset_busy;
    end
  end

  // status word built from the package bit positions
  always_comb begin
    status_word = '0;
    status_word[ST_SECURED] = secured;
    status_word[ST_BUSY] = (prog_state != PSS_IDLE);
    status_word[ST_RESET_DONE] = !reset_busy;
    status_word[ST_READ_DENIED] = read_denied;
  end

  // word picked for readback; passed on only while the cell is open
  assign cfg_word = cfg[cfg_addr*32 +: 32];

  // apb read data, registered; config reads refused while secured
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      read_denied <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !addr_ok;
      o_prdata <= '0;
      if (rd_en) begin
        unique case (i_paddr)
          OFS_STATUS: o_prdata <= status_word;
          OFS_SIG_LO: o_prdata <= user_signature[31:0]; // see [R02]
          OFS_SIG_HI: o_prdata <= user_signature[63:32];
          OFS_CFG_ADDR: o_prdata <= 32'(cfg_addr);
          OFS_CFG_DATA: begin
            if (secured) begin
              o_prdata <= DENIED_DATA; // see [R04]
              o_pslverr <= 1'b1;
              read_denied <= 1'b1;
            end else begin
              o_prdata <= cfg_word;
            end
          end
          OFS_PRELOAD: o_prdata <= {8'h00, polarity, 8'h00, preload_val};
          OFS_CHECKSUM: o_prdata <= checksum; // see [R03]
          default: o_prdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pss_pkg.sv ----
// package: constants for the signature, security and register reset block
package pss_pkg;
  localparam int SIG_BITS = 64;
  localparam int NUM_REGS = 8;
  localparam int CFG_WORDS = 8;
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SIG_LO = 8'h08;
  localparam logic [7:0] OFS_SIG_HI = 8'h0C;
  localparam logic [7:0] OFS_CFG_ADDR = 8'h10;
  localparam logic [7:0] OFS_CFG_DATA = 8'h14;
  localparam logic [7:0] OFS_PRELOAD = 8'h18;
  localparam logic [7:0] OFS_CHECKSUM = 8'h1C;
  // control bit positions
  localparam int CTRL_PROG_START = 0;
  localparam int CTRL_SECURE = 1;
  localparam int CTRL_PRELOAD = 2;
  // preload register: lowest bit of the stored polarity field
  localparam int PRELOAD_POL_LSB = 16;
  // status bit positions
  localparam int ST_SECURED = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_RESET_DONE = 2;
  localparam int ST_READ_DENIED = 3;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int RESET_MAX_US = 45;
  localparam int RESET_CYCLES = (RESET_MAX_US * (CLK_HZ / 1000000));
  localparam logic [31:0] DENIED_DATA = 32'h00000000;
  typedef enum logic [1:0] {
    PSS_IDLE = 2'b00,
    PSS_ERASE = 2'b01,
    PSS_WRITE = 2'b11
  } pss_prog_t;
endpackage

// ---- rtl/pss_checksum.sv ----
// checksum over configuration words and the user signature
`timescale 1ns/100ps
`default_nettype none
module pss_checksum
  import pss_pkg::*;
#(
  parameter int WORDS = CFG_WORDS
) (
  input wire logic [WORDS*32-1:0] i_cfg,
  input wire logic [SIG_BITS-1:0] i_sig,
  output logic [31:0] o_sum
);
  logic [31:0] part [WORDS+2];
  assign part[0] = i_sig[31:0];
  assign part[1] = i_sig[63:32];
  // one summing stage per word; signature words are in the sum too (see [R03])
  genvar g;
  for (g = 0; g < WORDS; g++) begin : g_sum
    assign part[g+2] = part[g+1] + i_cfg[g*32 +: 32] + ((g == 0) ? part[0] : 32'h00000000);
  end
  assign o_sum = part[WORDS+1];
endmodule
`default_nettype wire

// ---- rtl/pss_outreg.sv ----
// registered outputs with preload and power-up clear
`timescale 1ns/100ps
`default_nettype none
module pss_outreg
  import pss_pkg::*;
#(
  parameter int N = NUM_REGS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_load,
  input wire logic [N-1:0] i_load_val,
  input wire logic [N-1:0] i_next,
  input wire logic i_run,
  output logic [N-1:0] o_q
);
  // per register: clear wins, then preload, then normal update
  genvar g;
  for (g = 0; g < N; g++) begin : g_reg
    always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_clr) begin
        o_q[g] <= 1'b0; // see [R09]
      end else if (i_load) begin
        o_q[g] <= i_load_val[g]; // bypasses feedback, see [R07]
      end else if (i_run) begin
        o_q[g] <= i_next[g];
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/pss_chk.sv ----
// checker: bus answers, security, preload and reset relations at the top ports
`timescale 1ns/100ps
`default_nettype none
module pss_chk
  import pss_pkg::*;
#(
  parameter int RESET_COUNT = RESET_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NUM_REGS-1:0] o_pin,
  input wire logic o_reset_done
);
  localparam int DONE_MAX = RESET_COUNT + 3;
  logic [NUM_REGS-1:0] pl = '0;
  logic sec = 1'b0;
  wire logic acc = i_psel && i_penable && o_pready;
  wire logic wr_ctl = acc && i_pwrite && (i_paddr == OFS_CTRL);
  wire logic rd_cfg = acc && !i_pwrite && (i_paddr == OFS_CFG_DATA);
  // shadows kept through reset: the cell is nonvolatile, so reset must not clear sec
  always_ff @(posedge I_REF_CLK) begin
    if (acc && i_pwrite && i_paddr == OFS_PRELOAD) pl <= i_pwdata[NUM_REGS-1:0];
  end
  always_ff @(posedge I_REF_CLK) begin
    if (wr_ctl && i_pwdata[CTRL_PROG_START]) sec <= 1'b0;
    else if (wr_ctl && i_pwdata[CTRL_SECURE]) sec <= 1'b1;
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_preload;
    wr_ctl && i_pwdata[CTRL_PRELOAD];
  endsequence
  sequence s_released;
    $rose(I_RESET_N);
  endsequence
  a_bus_answer: assert property ((i_psel && !i_penable) |=> o_pready ##1 !o_pready)
    else $error("no single-cycle answer to a setup cycle");
  a_sig_open: assert property ((acc && !i_pwrite && i_paddr[7:3] == 5'h01) |-> !o_pslverr)
    else $error("signature read refused");
  a_cfg_denied: assert property (rd_cfg && sec |-> o_pslverr && o_prdata == DENIED_DATA)
    else $error("configuration readable while secured");
  a_cfg_open: assert property (rd_cfg && !sec |-> !o_pslverr)
    else $error("configuration refused after reprogramming");
  a_preload_pin: assert property (s_preload |-> ##[1:4] o_pin == ~pl)
    else $error("preload value never reached the pins");
  a_done_bound: assert property (s_released |-> (!o_reset_done)[*4] ##[1:DONE_MAX] o_reset_done)
    else $error("reset done early or late");
  a_done_holds: assert property (o_reset_done |=> o_reset_done)
    else $error("reset done dropped");
  a_pins_high: assert property (!o_reset_done |-> o_pin == '1)
    else $error("pins not high before reset done");
endmodule
bind pss_top pss_chk #(.RESET_COUNT(RESET_COUNT)) u_chk (.I_REF_CLK(I_REF_CLK),
  .I_RESET_N(I_RESET_N), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_pin(o_pin), .o_reset_done(o_reset_done));
`default_nettype wire

// ---- test/pss_pins.sv ----
// pin-side model: drives chosen input pins, lets the others go undriven
`timescale 1ns/100ps
`default_nettype none
module pss_pins (
  input wire logic i_clk,
  input wire logic [7:0] i_drive,
  input wire logic [7:0] i_val,
  output logic [7:0] o_pin,
  output logic [7:0] o_float
);
  logic tog = 1'b0;
  // released lines flip each cycle, so a stale level never passes for the pull-up
  always_ff @(posedge i_clk) tog <= ~tog;
  assign o_float = ~i_drive;
  assign o_pin = (i_val & i_drive) | ({8{tog}} & ~i_drive);
endmodule
`default_nettype wire

// ---- test/test_pld_signature_security_reset.sv ----
// self-checking bench for the signature, security and register reset block
`timescale 1ns/100ps
`default_nettype none
module test_pld_signature_security_reset
  import pss_pkg::*;
();
  localparam int RC = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00, oe = 8'hFF, drv = 8'h00, val = 8'h00, pv, pin, flt, pout, poe;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, done, err;
  logic [31:0] cfg [CFG_WORDS];
  logic [63:0] sig;
  int n_mismatch = 0, compares = 0, n;
  always #20 clk = ~clk;
  pss_pins u_pins (.i_clk(clk), .i_drive(drv), .i_val(val), .o_pin(pin), .o_float(flt));
  pss_top #(.RESET_COUNT(RC)) uut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin(pin), .i_pin_float(flt), .i_oe(oe),
    .o_pin(pout), .o_pin_oe(poe), .o_reset_done(done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus transfer; request held until pready is sampled, bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic cfg_rd(input int i);
    apb(1'b1, OFS_CFG_ADDR, 32'(i));
    apb(1'b0, OFS_CFG_DATA, 32'h0);
  endtask
  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 4 * RC) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // expected checksum: signature halves plus every configuration word
  function automatic logic [31:0] csum();
    logic [31:0] s;
    s = sig[31:0] + sig[63:32];
    foreach (cfg[i]) s += cfg[i];
    return s;
  endfunction
  initial begin
    void'($urandom(32'h16E45808));
    repeat (8) @(posedge clk);
    chk({24'h0, pout}, 32'h000000FF);
    chk({24'h0, poe}, 32'h00000000);
    rst_n <= 1'b1;
    wait_done();
    chk(32'(n > RC / 2 && n <= RC + 3), 32'h1);
    chk({24'h0, pout}, 32'h000000FF);
    $display("test reset done");
    // program cycle: erase runs by itself first, then fresh words go in
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    foreach (cfg[i]) begin
      cfg[i] = $urandom;
      apb(1'b1, OFS_CFG_ADDR, 32'(i));
      apb(1'b1, OFS_CFG_DATA, cfg[i]);
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    sig = {$urandom, $urandom};
    apb(1'b1, OFS_SIG_LO, sig[31:0]);
    apb(1'b1, OFS_SIG_HI, sig[63:32]);
    foreach (cfg[i]) begin
      cfg_rd(i);
      chk(rd, cfg[i]);
    end
    apb(1'b0, OFS_SIG_LO, 32'h0);
    chk(rd, sig[31:0]);
    apb(1'b0, OFS_CHECKSUM, 32'h0);
    chk(rd, csum());
    $display("test program done");
    // secured: configuration refused, signature still readable
    apb(1'b1, OFS_CTRL, 32'h2);
    cfg_rd(2);
    chk(rd, DENIED_DATA);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hD);
    apb(1'b0, OFS_SIG_HI, 32'h0);
    chk(rd, sig[63:32]);
    chk({31'h0, err}, 32'h0);
    // starting a reprogramming cycle clears the cell in its erase phase, and it leaves nothing to read back
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_SECURED]}, 32'h0);
    cfg_rd(5);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test security done");
    // preload corners in the second and third passes, then random states with random pin traffic
    // the first pass leaves every pin undriven, so all of them must read one
    for (int t = 0; t < 6; t++) begin
      val <= 8'($urandom);
      drv <= (t == 0) ? 8'h00 : 8'($urandom);
      oe <= 8'($urandom);
      pv = (t == 1) ? 8'h00 : (t == 2) ? 8'hFF : 8'($urandom);
      apb(1'b1, OFS_PRELOAD, {24'h0, pv});
      apb(1'b1, OFS_CTRL, 32'h4);
      repeat (3) @(posedge clk);
      chk({24'h0, pout}, {24'h0, ~pv});
      @(posedge clk);
      chk({24'h0, pout}, {24'h0, ~((val & drv) | ~drv)});
      chk({24'h0, poe}, {24'h0, oe});
    end
    $display("test preload done");
    // the cell survives a reset: secure, reset in mid-run, then try a readback
    apb(1'b1, OFS_CTRL, 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({24'h0, pout}, 32'h000000FF);
    chk({24'h0, poe}, 32'h00000000);
    rst_n <= 1'b1;
    wait_done();
    chk(32'(n > RC / 2 && n <= RC + 3), 32'h1);
    cfg_rd(1);
    chk(rd, DENIED_DATA);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hD);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
